// File: logic/psb_pkg.sv
package psb_pkg;
  // Timing figures in their own units and the clock rate.
  localparam int SYS_CLK_MHZ = 200;
  localparam int MAX_SELECT_LOW_TIME_NS = 4000;
  localparam int REFRESH_HIGH_NS = 15;
  localparam int BURST_SELECT_HIGH_GAP_NS = 5;
  localparam int SLEEP_ENTRY_HOLD_US = 150;
  localparam int SLEEP_EXIT_PULSE_US = 10;
  localparam int WAKEUP_DELAY_US = 150;
  // Derived cycle counts: least times round up, longest times round down.
  localparam int MAX_LOW_CYC = (MAX_SELECT_LOW_TIME_NS * SYS_CLK_MHZ) / 1000;
  localparam int REFRESH_HIGH_CYC = (REFRESH_HIGH_NS * SYS_CLK_MHZ + 999) / 1000 + 1;
  localparam int GAP_CYC = (BURST_SELECT_HIGH_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_HOLD_US * SYS_CLK_MHZ;
  localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_PULSE_US * SYS_CLK_MHZ;
  localparam int WAKEUP_CYC = WAKEUP_DELAY_US * SYS_CLK_MHZ;
  // Field layout of the bus configuration word.
  localparam int CFG_LAT_LSB = 11;
  localparam int CFG_LAT_W = 3;
  localparam int CFG_WAIT_TIMING_BIT = 8;
  localparam int CFG_SLEEP_BIT = 4;
  localparam int CFG_MODE_BIT = 15;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] ROW_END_COL = 4'hF;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  typedef enum logic [2:0] {PSB_IDLE, PSB_LAT, PSB_WRITE, PSB_READ, PSB_ROWWAIT} psb_state_t;
endpackage

// File: logic/psb_fifo.sv
`timescale 1ns/1ps
module psb_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic in_valid, // Write word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Word written.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Drain takes word.
  output logic [WIDTH-1:0] out_data // Oldest word, read straight from memory.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_r != AW'(0) + (AW+1)'(DEPTH)) || pop;
  assign out_valid = count_r != '0;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: logic/psb_core.sv
`timescale 1ns/1ps
// Function
// [R1] Controller refreshes within max select-low time.
// [R2] Select high clocked or long counts refresh.
// [R3] Write strobe low no longer than limit.
// [R4] Address setup needed only for slow select.
// [R5] Read suspend holds burst clock static.
// [R6] Suspended read keeps driving valid data.
// [R7] Select rises before second/third clock.
// [R8] Burst write waits latency-count cycles.
// [R9] Row crossing read waits latency-count cycles.
// [R10] Latency clocks equal code plus one.
// [R11] Select high 150 us after sleep enable.
// [R12] Select low 10 us exits deep sleep.
// [R13] Wait wakeup delay before next command.
// [R14] Select high gap between async operations.
// [R15] Select high gap between burst operations.
// [R16] Select rises switching async and variable burst.
// [R17] Back-to-back bursts within select-low limit.
// [R18] Synchronous mode needs gap after async writes.
// [R19] Controller timer forces refresh opportunities; psb_host has no timer and keeps frames short instead.
// [R20] One write word per edge after latency.
module psb_core
  import psb_pkg::*;
#(
  parameter int SLEEP_EXIT_CYCLES = SLEEP_EXIT_CYC,
  parameter int WAKEUP_CYCLES = WAKEUP_CYC
) (
  input wire logic sys_clk, // System clock, 200 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic burst_clk, // Burst clock pin, sampled.
  input wire logic select_n, // Select pin, active low.
  input wire logic address_valid_strobe_n, // Address valid, active low.
  input wire logic write_n, // Write strobe, active low.
  input wire logic output_drive_n, // Output enable, active low.
  input wire logic [1:0] byte_lane_selects_n, // Byte lanes, active low.
  input wire logic [3:0] col_addr, // Low address bits, row column.
  input wire logic [DATA_W-1:0] dq_in, // Data pins in.
  output logic [DATA_W-1:0] dq_out, // Data pins out.
  output logic dq_oe, // Data pins driven.
  output logic wait_out, // Wait indication, active high.
  input wire logic [DATA_W-1:0] bus_config_register, // Configuration word.
  input wire logic [DATA_W-1:0] read_word, // Array data for reads.
  output logic wr_valid, // Written word available.
  input wire logic wr_ready, // Array takes written word.
  output logic [DATA_W+1:0] wr_word, // Lanes and data.
  output logic deep_sleep, // Deep sleep state.
  output logic refresh_ok // Refresh opportunity seen.
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] clk_s_r, sel_s_r, adv_s_r, we_s_r, oe_s_r;
  logic clk_d_r;
  logic clk_rise;
  // Wait as it stood on the pin when the controller saw the burst clock rise.
  // The edge reaches the sequencer two cycles late, so wait is delayed to match.
  logic [1:0] wait_seen_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      clk_s_r <= 2'h0;
      sel_s_r <= 2'h3;
      adv_s_r <= 2'h3;
      we_s_r <= 2'h3;
      oe_s_r <= 2'h3;
      clk_d_r <= 1'b0;
      wait_seen_r <= 2'h0;
    end
    else
    begin
      clk_s_r <= {clk_s_r[0], burst_clk};
      sel_s_r <= {sel_s_r[0], select_n};
      adv_s_r <= {adv_s_r[0], address_valid_strobe_n};
      we_s_r <= {we_s_r[0], write_n};
      oe_s_r <= {oe_s_r[0], output_drive_n};
      clk_d_r <= clk_s_r[1];
      wait_seen_r <= {wait_seen_r[0], wait_out};
    end
  end
  // Only rising edges are active; a clock held at either level suspends the burst.
  assign clk_rise = clk_s_r[1] && !clk_d_r; // see [R5]
  logic sel_lo;
  assign sel_lo = !sel_s_r[1];

  // ****************************************
  // Burst sequencer
  // ****************************************
  function automatic logic [3:0] lat_clocks(input logic [CFG_LAT_W-1:0] code);
    return 4'(code) + 4'h1; // see [R10]
  endfunction
  psb_state_t state_r;
  logic [3:0] lat_cnt_r;
  logic is_write_r;
  logic [3:0] col_r;
  logic [3:0] lat_load;
  logic fifo_in_ready;
  assign lat_load = lat_clocks(bus_config_register[CFG_LAT_LSB +: CFG_LAT_W]);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !sel_lo)
    begin
      state_r <= PSB_IDLE;
      lat_cnt_r <= CNT_ZERO;
      is_write_r <= 1'b0;
      col_r <= CNT_ZERO;
    end
    else if (clk_rise)
    begin
      case (state_r)
        PSB_IDLE:
        begin
          if (!adv_s_r[1])
          begin
            state_r <= PSB_LAT;
            lat_cnt_r <= lat_load - 4'h1; // see [R8]
            is_write_r <= !we_s_r[1];
            col_r <= col_addr;
          end
        end
        PSB_LAT:
        begin
          if (lat_cnt_r == CNT_ZERO)
          begin
            state_r <= is_write_r ? PSB_WRITE : PSB_READ;
          end
          else
          begin
            lat_cnt_r <= lat_cnt_r - 4'h1;
          end
        end
        PSB_WRITE, PSB_READ:
        begin
          // A write stalls while the array is backed up; the column then holds. Reads never stall.
          if (!is_write_r || !wait_seen_r[1]) // see [R20]
          begin
            col_r <= col_r + 4'h1;
            if (col_r == ROW_END_COL)
            begin
              state_r <= PSB_ROWWAIT;
              lat_cnt_r <= lat_load - 4'h1;
            end
          end
        end
        PSB_ROWWAIT:
        begin
          if (lat_cnt_r == CNT_ZERO)
          begin
            state_r <= is_write_r ? PSB_WRITE : PSB_READ; // see [R9]
          end
          else
          begin
            lat_cnt_r <= lat_cnt_r - 4'h1;
          end
        end
        default: state_r <= PSB_IDLE;
      endcase
    end
  end

  // ****************************************
  // Wait and data pins
  // ****************************************
  logic wait_nxt;
  assign wait_nxt = (state_r == PSB_LAT) || (state_r == PSB_ROWWAIT) ||
                    (state_r == PSB_WRITE && !fifo_in_ready);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wait_out <= 1'b0;
      dq_oe <= 1'b0;
      dq_out <= '0;
    end
    else
    begin
      wait_out <= sel_lo && wait_nxt; // see [R8] [R9]
      // Output drive follows select, the enable and the read state, not the clock, so a stopped clock keeps data valid.
      dq_oe <= sel_lo && !oe_s_r[1] && state_r == PSB_READ; // see [R6]
      if (state_r == PSB_READ && clk_rise)
      begin
        dq_out <= read_word;
      end
    end
  end

  // ****************************************
  // Write data buffer
  // ****************************************
  logic fifo_push;
  assign fifo_push = sel_lo && clk_rise && state_r == PSB_WRITE && !wait_seen_r[1]; // see [R20]
  logic fifo_out_valid;
  logic fifo_out_ready;
  // The buffer only gives up a word when the output register is free or being taken.
  assign fifo_out_ready = !wr_valid || wr_ready;
  logic [DATA_W+1:0] fifo_out_data;
  psb_fifo #(.WIDTH(DATA_W+2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({byte_lane_selects_n, dq_in}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_valid <= 1'b0;
      wr_word <= '0;
    end
    else
    begin
      if (fifo_out_ready)
      begin
        wr_valid <= fifo_out_valid;
        wr_word <= fifo_out_data;
      end
    end
  end

  // ****************************************
  // Refresh opportunity and deep sleep
  // ****************************************
  logic [3:0] high_cnt_r;
  logic [31:0] sleep_cnt_r;
  logic sleep_r;
  logic sleep_armed_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      high_cnt_r <= CNT_ZERO;
      refresh_ok <= 1'b0;
    end
    else
    begin
      high_cnt_r <= sel_lo ? CNT_ZERO : (high_cnt_r == 4'hF ? high_cnt_r : high_cnt_r + 4'h1);
      refresh_ok <= !sel_lo && (clk_rise || high_cnt_r >= 4'(REFRESH_HIGH_CYC)); // see [R2]
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sleep_r <= 1'b0;
      sleep_armed_r <= 1'b0;
      sleep_cnt_r <= '0;
      deep_sleep <= 1'b0;
    end
    else
    begin
      sleep_armed_r <= !bus_config_register[CFG_SLEEP_BIT];
      if (!sleep_r)
      begin
        sleep_cnt_r <= '0;
        if (sleep_armed_r && !sel_lo)
        begin
          sleep_r <= 1'b1;
        end
      end
      else if (sel_lo)
      begin
        sleep_cnt_r <= sleep_cnt_r + 32'h1;
        if (sleep_cnt_r >= 32'(SLEEP_EXIT_CYCLES - 1)) // see [R12]
        begin
          sleep_r <= 1'b0;
        end
      end
      else
      begin
        sleep_cnt_r <= '0;
      end
      deep_sleep <= sleep_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_wait_in_lat: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R8]
    (sel_lo && state_r == PSB_LAT) |=> wait_out)
    else $error("Wait not shown during latency.");
  a_lat_load: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R10]
    (state_r == PSB_IDLE && sel_lo && clk_rise && !adv_s_r[1]) |=>
    lat_cnt_r == lat_load - 4'h1)
    else $error("Latency count not code plus one.");
  a_row_wait: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R9]
    (sel_lo && clk_rise && state_r == PSB_READ && col_r == ROW_END_COL) |=>
    state_r == PSB_ROWWAIT)
    else $error("Row crossing did not wait.");
  a_suspend_data: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
    (state_r == PSB_READ && !clk_rise && $stable(state_r)) |=> $stable(dq_out))
    else $error("Suspended data changed.");
  a_write_push: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R20]
    (fifo_push && fifo_in_ready) |=> ##1 wr_valid || fifo_out_valid)
    else $error("Written word lost.");
  a_refresh_seen: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R2]
    (!sel_lo && clk_rise) |=> refresh_ok)
    else $error("Clocked select high not seen.");
  a_oe_drive: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
    (oe_s_r[1]) |=> !dq_oe)
    else $error("Data driven with enable high.");
  a_sleep_exit: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R12]
    (sleep_r && !sel_lo) |=> sleep_r)
    else $error("Sleep left without select low.");
endmodule

// File: tb/psb_host.sv
`timescale 1ns/1ps
module psb_host
  import psb_pkg::*;
(
  input wire logic wait_out, // Wait from the device.
  output logic burst_clk, // Burst clock, static outside frames.
  output logic select_n, // Select, active low.
  output logic address_valid_strobe_n, // Address valid, active low.
  output logic write_n, // Write strobe, active low.
  output logic output_drive_n, // Output enable, active low.
  output logic [1:0] byte_lane_selects_n, // Byte lanes, active low.
  output logic [3:0] col_addr, // Start column.
  output logic [DATA_W-1:0] dq_in // Write data.
);
  // ****************************************
  // Controller side of the burst bus
  // ****************************************
  logic [DATA_W+1:0] exp_q[$];
  initial
  begin
    {burst_clk, byte_lane_selects_n, col_addr, dq_in} = 23'h0;
    {select_n, address_valid_strobe_n, write_n, output_drive_n} = 4'hF;
  end
  // Frames stay short so select never stays low near its limit.
  task automatic burst(input logic wr, input logic [3:0] col, input int n, output int waits);
    int taken;
    int edges;
    taken = 0;
    edges = 0;
    waits = 0;
    select_n = 1'b0;
    address_valid_strobe_n = 1'b0;
    write_n = !wr;
    output_drive_n = wr;
    col_addr = col;
    byte_lane_selects_n = 2'($urandom);
    dq_in = 16'($urandom);
    #32 burst_clk = 1'b1;
    #32 burst_clk = 1'b0;
    address_valid_strobe_n = 1'b1;
    while (taken < n && edges < 400)
    begin
      #31;
      if (wait_out === 1'b1)
        waits++;
      else
      begin
        taken++;
        if (wr)
          exp_q.push_back({byte_lane_selects_n, dq_in});
      end
      #1 burst_clk = 1'b1;
      #32 burst_clk = 1'b0;
      if (wr && wait_out !== 1'b1)
      begin
        byte_lane_selects_n = 2'($urandom);
        dq_in = 16'($urandom);
      end
      edges++;
    end
  endtask
  // The clock is left low, so a read frame sits suspended until released.
  task automatic end_burst();
    select_n = 1'b1;
    write_n = 1'b1;
    output_drive_n = 1'b1;
    dq_in = ~dq_in;
    byte_lane_selects_n = ~byte_lane_selects_n;
    #150;
  endtask
  task automatic sleep_exit(input int ns);
    select_n = 1'b0;
    #(ns);
    select_n = 1'b1;
    #100;
  endtask
endmodule

// File: tb/psb_write_burst_sequencing_tb.sv
`timescale 1ns/1ps
module psb_write_burst_sequencing_tb;
  import psb_pkg::*;
  // ****************************************
  // Bench
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [DATA_W-1:0] bus_config_register = 16'h0010;
  logic [DATA_W-1:0] read_word = 16'h0000;
  logic wr_ready = 1'b1;
  logic [1:0] rdy_mode = 2'h2;
  logic burst_clk, select_n, avs_n, write_n, oe_n, dq_oe, wait_out, wr_valid;
  logic deep_sleep, refresh_ok;
  logic [1:0] lanes_n;
  logic [3:0] col;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [DATA_W+1:0] wr_word;
  int failures = 0;
  int tests_run = 0;
  int w;
  int c;
  always #2.5 sys_clk = ~sys_clk;
  psb_host u_host(.wait_out(wait_out), .burst_clk(burst_clk), .select_n(select_n),
    .address_valid_strobe_n(avs_n), .write_n(write_n), .output_drive_n(oe_n),
    .byte_lane_selects_n(lanes_n), .col_addr(col), .dq_in(dq_in));
  psb_core #(.SLEEP_EXIT_CYCLES(20), .WAKEUP_CYCLES(20)) dut(.sys_clk(sys_clk),
    .rst_n(rst_n), .burst_clk(burst_clk), .select_n(select_n),
    .address_valid_strobe_n(avs_n), .write_n(write_n), .output_drive_n(oe_n),
    .byte_lane_selects_n(lanes_n), .col_addr(col), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .wait_out(wait_out), .bus_config_register(bus_config_register),
    .read_word(read_word), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .deep_sleep(deep_sleep), .refresh_ok(refresh_ok));
  always @(negedge sys_clk)
    wr_ready <= rdy_mode == 2'h2 || (rdy_mode == 2'h1 && $urandom % 2 == 0);
  task automatic chk_word(input string name, input logic [DATA_W+1:0] e,
    input logic [DATA_W+1:0] g);
    tests_run++;
    if (e !== g)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic chk_flag(input string name, input logic e, input logic g);
    chk_word(name, {17'h0, e}, {17'h0, g});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (rst_n && wr_valid === 1'b1 && wr_ready)
    begin
      if (u_host.exp_q.size() == 0)
      begin
        failures++;
        $display("mismatch wr_word expected none seen %h", wr_word);
      end
      else
        chk_word("wr_word", u_host.exp_q.pop_front(), wr_word);
    end
  initial
  begin
    #400000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    w = $urandom(4788);
    repeat (3) @(negedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(negedge sys_clk);
    // Select idles high, so a refresh opportunity is already showing.
    chk_word("reset_outs", 18'h4, {13'h0, wr_valid, deep_sleep, refresh_ok, wait_out, dq_oe});
    for (int i = 0; i < 3; i++)
    begin
      c = (i == 0) ? 2 : (i == 1) ? 4 : 1 + $urandom % 6;
      bus_config_register[13:11] = 3'(c);
      @(negedge sys_clk);
      u_host.burst(1'b1, 4'h0, 4, w);
      chk_word("write_waits", 18'(c + 1), 18'(w));
      u_host.end_burst();
      read_word = 16'($urandom);
      @(negedge sys_clk);
      u_host.burst(1'b0, 4'hE, 4, w);
      chk_word("read_waits", 18'(2 * c + 2), 18'(w));
      #500;
      chk_word("suspend_data", {2'h0, read_word}, {2'h0, dq_out});
      chk_flag("suspend_drive", 1'b1, dq_oe);
      u_host.end_burst();
      chk_flag("refresh_ok", 1'b1, refresh_ok);
    end
    // The drain stalls long enough for the buffer to fill and push back.
    rdy_mode = 2'h0;
    @(negedge sys_clk);
    fork
      u_host.burst(1'b1, 4'h8, 20, w);
      begin
        #2500;
        rdy_mode = 2'h1;
      end
    join
    u_host.end_burst();
    repeat (200) @(negedge sys_clk);
    chk_word("pending", 18'h0, 18'(u_host.exp_q.size()));
    // Sleep follows the enable while select is high; select then stays high for the hold.
    bus_config_register[CFG_SLEEP_BIT] = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk_flag("sleep_early", 1'b1, deep_sleep);
    repeat (SLEEP_ENTRY_CYC) @(negedge sys_clk);
    chk_flag("sleep_entry", 1'b1, deep_sleep);
    bus_config_register[CFG_SLEEP_BIT] = 1'b1;
    u_host.sleep_exit(200);
    repeat (60) @(negedge sys_clk);
    chk_flag("sleep_exit", 1'b0, deep_sleep);
    tally_and_finish();
  end
endmodule
